// ==== src/speed_status_pkg.sv ====
package speed_status_pkg;
  localparam int unsigned SPEED_W = 16;
  localparam logic [7:0] OFS_ROTATION = 8'h00;
  localparam logic [7:0] OFS_MATCH = 8'h04;
  localparam logic [7:0] OFS_REACHED = 8'h08;
  localparam logic [7:0] OFS_NEAR_ZERO = 8'h0C;
  localparam logic [7:0] OFS_MAIN_SRC = 8'h10;
  localparam logic [7:0] OFS_AUX_SRC = 8'h14;
  localparam logic [7:0] OFS_CLAMP = 8'h18;
  localparam logic [7:0] OFS_FILTER = 8'h1C;
  localparam logic [7:0] OFS_KEYPAD = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [15:0] RST_ROTATION = 16'h0014;
  localparam logic [15:0] RST_MATCH = 16'h000A;
  localparam logic [15:0] RST_REACHED = 16'h03E8;
  localparam logic [15:0] RST_NEAR_ZERO = 16'h000A;
  localparam logic [1:0] RST_MAIN_SRC = 2'h0;
  localparam logic [1:0] RST_AUX_SRC = 2'h1;
  localparam logic [15:0] RST_CLAMP = 16'h000A;
  localparam logic [3:0] RST_FILTER = 4'h2;
  localparam logic [15:0] RST_KEYPAD = 16'h0000;
  localparam logic [15:0] MAX_ROTATION = 16'd1000;
  localparam logic [15:0] MAX_MATCH = 16'd100;
  localparam logic [15:0] MIN_REACHED = 16'd10;
  localparam logic [15:0] MAX_SPEED_SET = 16'd6000;
  localparam logic [15:0] MIN_NEAR_ZERO = 16'd1;
  localparam logic signed [15:0] MAX_KEYPAD = 16'sd3000;
  localparam logic [1:0] SRC_MAX = 2'h2;
  localparam int unsigned STATUS_ROTATING = 0;
  localparam int unsigned STATUS_MATCHED = 1;
  localparam int unsigned STATUS_REACHED = 2;
  localparam int unsigned STATUS_NEAR_ZERO = 3;
  localparam int unsigned STATUS_CLAMPED = 4;

  typedef enum logic [1:0] {
    SRC_KEYPAD = 2'h0,
    SRC_ANALOG_ONE = 2'h1,
    SRC_ANALOG_TWO = 2'h2
  } torque_src_t;

  typedef enum logic [1:0] {
    CLAMP_FOLLOW = 2'b01,
    CLAMP_HOLD = 2'b10
  } clamp_state_t;

  typedef struct packed {
    logic rotating;
    logic matched;
    logic reached;
    logic near_zero;
  } speed_flags_t;

  typedef struct packed {
    logic [15:0] rotation;
    logic [15:0] match;
    logic [15:0] reached;
    logic [15:0] near_zero;
  } thresholds_t;

  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] clip16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clip16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// ==== src/speed_lowpass.sv ====
`timescale 1ns/100ps
`default_nettype none
module speed_lowpass #(
  parameter int unsigned W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample_valid,
  input wire logic signed [W-1:0] speed_in,
  input wire logic [3:0] shift,
  output logic signed [W-1:0] speed_out
);
  if (W < 8) begin : g_bad_width
    $error("speed_lowpass width too small");
  end
  // extra fraction bits keep small steps from stalling the filter
  logic signed [W+15:0] acc_q;
  logic signed [W+15:0] target;
  assign target = {speed_in, 16'h0000};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= '0;
    end else if (sample_valid) begin
      acc_q <= acc_q + ((target - acc_q) >>> shift);
    end
  end
  assign speed_out = acc_q[W+15:16];
endmodule
`default_nettype wire

// ==== src/speed_compare.sv ====
`timescale 1ns/100ps
`default_nettype none
module speed_compare
  import speed_status_pkg::*;
(
  input wire logic signed [15:0] speed_filt,
  input wire logic signed [15:0] speed_ref,
  input wire thresholds_t thr,
  input wire logic running,
  input wire logic speed_mode,
  output speed_flags_t flags
);
  logic [15:0] mag;
  logic signed [16:0] diff;
  logic [16:0] diff_mag;
  always_comb begin
    mag = abs16(speed_filt);
    diff = 17'(speed_filt) - 17'(speed_ref);
    diff_mag = diff[16] ? 17'(-diff) : 17'(diff);
    flags.rotating = (mag >= thr.rotation);
    flags.matched = running && speed_mode && (diff_mag <= {1'b0, thr.match});
    flags.reached = (mag > thr.reached);
    flags.near_zero = (mag < thr.near_zero);
  end
endmodule
`default_nettype wire

// ==== src/speed_status_and_torque_source.sv ====
// What this block does
// - clamp when enabled, speed mode, small reference
// - leave clamp when reference exceeds threshold
// - no clamp without clamp enable input
// - rotating when filtered speed reaches threshold
// - not rotating below rotation threshold
// - rotating ignores run status and mode
// - matched when speed error within window
// - not matched when error exceeds window
// - matched forced low unless running speed mode
// - reached when filtered speed exceeds threshold
// - not reached at or below threshold
// - reached ignores run status and mode
// - near zero below zero speed threshold
// - near zero cleared otherwise
// - near zero ignores run status and mode
// - comparisons use separately filtered speed
// - main torque source 0..2, stopped only
// - aux torque source 0..2, default one
// - aux encoding keypad, analog one, two
// - keypad torque within plus minus 300 percent
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module speed_status_and_torque_source
  import speed_status_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] speed_reference,
  input wire logic running,
  input wire logic speed_mode,
  input wire logic clamp_enable_input,
  input wire logic signed [15:0] analog_input_one,
  input wire logic signed [15:0] analog_input_two,
  output logic rotating_output,
  output logic speed_matched_output,
  output logic speed_reached_output,
  output logic near_zero_output,
  output logic clamp_active,
  output logic signed [15:0] speed_command,
  output logic signed [15:0] main_torque_ref,
  output logic signed [15:0] aux_torque_ref
);
  import speed_status_pkg::*;

  thresholds_t thr_q;
  logic [1:0] main_src_q;
  logic [1:0] aux_src_q;
  logic [15:0] clamp_thr_q;
  logic [3:0] filter_q;
  logic signed [15:0] keypad_q;
  logic signed [15:0] speed_filt;
  speed_flags_t flags;
  clamp_state_t clamp_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic rd_pend_q;
  logic [7:0] rd_addr_q;
  logic bus_go;
  logic clamp_cond;

  assign bus_go = hsel && hready && htrans[1];

  // stop-only fields just keep their value while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= bus_go && hwrite;
      rd_pend_q <= bus_go && !hwrite;
      if (bus_go) begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_q.rotation <= RST_ROTATION;
      thr_q.match <= RST_MATCH;
      thr_q.reached <= RST_REACHED;
      thr_q.near_zero <= RST_NEAR_ZERO;
      clamp_thr_q <= RST_CLAMP;
      filter_q <= RST_FILTER;
      keypad_q <= RST_KEYPAD;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        OFS_ROTATION: thr_q.rotation <= clip16(hwdata[15:0], 16'h0000, MAX_ROTATION);
        OFS_MATCH: thr_q.match <= clip16(hwdata[15:0], 16'h0000, MAX_MATCH);
        OFS_REACHED: thr_q.reached <= clip16(hwdata[15:0], MIN_REACHED, MAX_SPEED_SET);
        OFS_NEAR_ZERO: thr_q.near_zero <= clip16(hwdata[15:0], MIN_NEAR_ZERO, MAX_SPEED_SET);
        OFS_CLAMP: clamp_thr_q <= clip16(hwdata[15:0], 16'h0000, MAX_SPEED_SET);
        OFS_FILTER: filter_q <= hwdata[3:0];
        OFS_KEYPAD: begin
          if ($signed(hwdata[15:0]) > MAX_KEYPAD) begin
            keypad_q <= MAX_KEYPAD;
          end else if ($signed(hwdata[15:0]) < -MAX_KEYPAD) begin
            keypad_q <= -MAX_KEYPAD;
          end else begin
            keypad_q <= $signed(hwdata[15:0]);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_src_q <= RST_MAIN_SRC;
      aux_src_q <= RST_AUX_SRC;
    end else if (wr_pend_q && !running && hwdata[15:0] <= 16'(SRC_MAX)) begin
      if (wr_addr_q == OFS_MAIN_SRC) begin
        main_src_q <= hwdata[1:0];
      end
      if (wr_addr_q == OFS_AUX_SRC) begin
        aux_src_q <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_go && !hwrite) begin
      case (haddr[7:0])
        OFS_ROTATION: hrdata <= {16'h0000, thr_q.rotation};
        OFS_MATCH: hrdata <= {16'h0000, thr_q.match};
        OFS_REACHED: hrdata <= {16'h0000, thr_q.reached};
        OFS_NEAR_ZERO: hrdata <= {16'h0000, thr_q.near_zero};
        OFS_MAIN_SRC: hrdata <= {30'h0, main_src_q};
        OFS_AUX_SRC: hrdata <= {30'h0, aux_src_q};
        OFS_CLAMP: hrdata <= {16'h0000, clamp_thr_q};
        OFS_FILTER: hrdata <= {28'h0, filter_q};
        OFS_KEYPAD: hrdata <= {16'h0000, keypad_q};
        OFS_STATUS: hrdata <= {27'h0, clamp_q == CLAMP_HOLD, near_zero_output, speed_reached_output,
                               speed_matched_output, rotating_output};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // zero wait states: the slave is always ready with an okay answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  speed_lowpass #(
    .W(SPEED_W)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_valid(sample_valid),
    .speed_in(motor_speed),
    .shift(filter_q),
    .speed_out(speed_filt)
  );

  speed_compare u_compare (
    .speed_filt(speed_filt),
    .speed_ref(speed_reference),
    .thr(thr_q),
    .running(running),
    .speed_mode(speed_mode),
    .flags(flags)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rotating_output <= 1'b0;
      speed_matched_output <= 1'b0;
      speed_reached_output <= 1'b0;
      near_zero_output <= 1'b0;
    end else begin
      rotating_output <= flags.rotating;
      speed_matched_output <= flags.matched;
      speed_reached_output <= flags.reached;
      near_zero_output <= flags.near_zero;
    end
  end

  assign clamp_cond = clamp_enable_input && speed_mode && (abs16(speed_reference) <= clamp_thr_q);

  // the position loop that really holds the shaft lives outside; here we freeze the command at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clamp_q <= CLAMP_FOLLOW;
    end else begin
      case (clamp_q)
        CLAMP_FOLLOW: clamp_q <= clamp_cond ? CLAMP_HOLD : CLAMP_FOLLOW;
        CLAMP_HOLD: clamp_q <= clamp_cond ? CLAMP_HOLD : CLAMP_FOLLOW;
        default: clamp_q <= CLAMP_FOLLOW;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clamp_active <= 1'b0;
      speed_command <= 16'sh0000;
    end else begin
      clamp_active <= clamp_cond;
      speed_command <= clamp_cond ? 16'sh0000 : speed_reference;
    end
  end

  function automatic logic signed [15:0] pick(input logic [1:0] sel, input logic signed [15:0] kp,
                                              input logic signed [15:0] a1, input logic signed [15:0] a2);
    case (sel)
      SRC_KEYPAD: pick = kp;
      SRC_ANALOG_ONE: pick = a1;
      SRC_ANALOG_TWO: pick = a2;
      default: pick = kp;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_torque_ref <= 16'sh0000;
      aux_torque_ref <= 16'sh0000;
    end else begin
      main_torque_ref <= pick(main_src_q, keypad_q, analog_input_one, analog_input_two);
      aux_torque_ref <= pick(aux_src_q, keypad_q, analog_input_one, analog_input_two);
    end
  end
endmodule
`default_nettype wire

// ==== tb/sst_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module sst_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic running,
  input wire logic speed_mode,
  input wire logic clamp_enable_input,
  input wire logic signed [15:0] speed_reference,
  input wire logic speed_matched_output,
  input wire logic clamp_active,
  input wire logic signed [15:0] speed_command
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_MATCH_GATED: assert property (speed_matched_output |-> $past(running) && $past(speed_mode))
    else $error("matched while stopped or not speed mode");
  AST_MATCH_MODE: assert property (!speed_mode [*2] |-> !speed_matched_output)
    else $error("matched outside speed mode");
  AST_CLAMP_MODE: assert property (clamp_active |-> $past(speed_mode))
    else $error("clamp outside speed mode");
  AST_CLAMP_ZERO: assert property (clamp_active |-> speed_command == 16'sh0)
    else $error("clamped command not zero");
  AST_CMD_FOLLOW: assert property (!clamp_active |-> speed_command == $past(speed_reference))
    else $error("command does not follow reference");
  AST_CLAMP_BIG: assert property ($past(speed_reference) > 16'sh1770 |-> !clamp_active)
    else $error("clamp with large reference");
  AST_CLAMP_ENABLE: assert property (clamp_active |-> $past(clamp_enable_input))
    else $error("clamp without enable");
  AST_CLAMP_OFF: assert property ($fell(clamp_enable_input) |=> !clamp_active)
    else $error("clamp kept after enable dropped");
endmodule
bind speed_status_and_torque_source sst_chk u_chk (.hclk, .hresetn, .running, .speed_mode, .clamp_enable_input,
  .speed_reference, .speed_matched_output, .clamp_active, .speed_command);
`default_nettype wire

// ==== tb/status_reader.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_reader
  import speed_status_pkg::*;
(
  input wire logic hclk,
  input wire speed_flags_t flags,
  output speed_flags_t seen
);
  // controller latches the output lines on the same rising hclk edge that clocks the block
  always_ff @(posedge hclk) begin
    seen <= flags;
  end
endmodule
`default_nettype wire

// ==== tb/speed_status_and_torque_source_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module speed_status_and_torque_source_tb_top;
  import speed_status_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sample_valid, running, speed_mode;
  logic clamp_enable_input, rotating_output, speed_matched_output, speed_reached_output;
  logic near_zero_output, clamp_active;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic signed [15:0] motor_speed, speed_reference, analog_input_one, analog_input_two;
  logic signed [15:0] speed_command, main_torque_ref, aux_torque_ref;
  speed_flags_t flags_w, seen;
  int bad_count, cmp_count;
  int sp[8] = '{19, 20, -20, 1000, 1001, -1001, 9, 10};
  logic [7:0] co[5] = '{OFS_ROTATION, OFS_MATCH, OFS_REACHED, OFS_NEAR_ZERO, OFS_KEYPAD};
  int cw[5] = '{2000, 200, 5, 0, 4000};
  int ce[5] = '{1000, 100, 10, 1, 3000};
  logic [15:0] tv[3] = '{16'h0BB8, 16'h0111, 16'h0222};
  assign hready = hreadyout;
  assign flags_w = {rotating_output, speed_matched_output, speed_reached_output, near_zero_output};
  speed_status_and_torque_source uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .sample_valid, .motor_speed, .speed_reference, .running,
    .speed_mode, .clamp_enable_input, .analog_input_one, .analog_input_two, .rotating_output,
    .speed_matched_output, .speed_reached_output, .near_zero_output, .clamp_active, .speed_command,
    .main_torque_ref, .aux_torque_ref);
  status_reader u_ctl (.hclk(hclk), .flags(flags_w), .seen(seen));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // address phase held until hready, then data phase until hready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic spd(input int s);
    @(posedge hclk);
    motor_speed <= 16'(s);
    sample_valid <= 1'b1;
    @(posedge hclk);
    sample_valid <= 1'b0;
    settle();
  endtask
  task automatic clampt(input logic en, input int r, input logic [16:0] e);
    @(posedge hclk);
    clamp_enable_input <= en;
    speed_reference <= 16'(r);
    settle();
    chk({clamp_active, speed_command}, e);
  endtask
  function automatic logic [3:0] expf(input int s, input int r, input logic rn, input logic md);
    int a = s < 0 ? -s : s;
    int e = s > r ? s - r : r - s;
    return {a >= 20, rn && md && e <= 10, a > 1000, a < 10};
  endfunction
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, sample_valid, running, speed_mode} = '0;
    {clamp_enable_input, motor_speed, speed_reference} = '0;
    hsize = 3'h2;
    analog_input_one = 16'sh0111;
    analog_input_two = 16'sh0222;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, OFS_REACHED, 0);
    chk(rdv, 32'(RST_REACHED));
    chk({hreadyout, hresp}, 2'b10);
    bus(0, OFS_AUX_SRC, 0);
    chk(rdv, 32'(RST_AUX_SRC));
    spd(1100);
    chk(seen, 4'b1000);
    bus(1, OFS_FILTER, 0);
    spd(0);
    chk(seen, 4'b0001);
    for (int i = 0; i < 8; i++) begin
      running <= i[0];
      speed_mode <= i[1];
      speed_reference <= 16'(sp[i] + (i % 3) * 6);
      spd(sp[i]);
      chk(seen, expf(sp[i], sp[i] + (i % 3) * 6, i[0], i[1]));
    end
    running <= 1'b1;
    speed_mode <= 1'b1;
    speed_reference <= 16'sd22;
    settle();
    chk(speed_matched_output, 1'b0);
    bus(1, OFS_ROTATION, 10);
    settle();
    chk(rotating_output, 1'b1);
    clampt(1, 10, 17'h10000);
    bus(0, OFS_STATUS, 0);
    chk(rdv, 32'h13);
    clampt(1, 11, 17'h0000B);
    clampt(1, 7000, 17'h01B58);
    clampt(0, 0, 17'h00000);
    for (int i = 0; i < 5; i++) begin
      bus(1, co[i], cw[i]);
      bus(0, co[i], 0);
      chk(rdv, ce[i]);
    end
    running <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      bus(1, OFS_MAIN_SRC, s);
      bus(1, OFS_AUX_SRC, s);
      settle();
      chk({main_torque_ref, aux_torque_ref}, {tv[s], tv[s]});
    end
    bus(1, OFS_AUX_SRC, 3);
    running <= 1'b1;
    bus(1, OFS_MAIN_SRC, 0);
    bus(0, OFS_MAIN_SRC, 0);
    chk(rdv, 32'h2);
    bus(0, OFS_AUX_SRC, 0);
    chk(rdv, 32'h2);
    bus(0, 8'h40, 0);
    chk(rdv, 32'h0);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
